// >>> rtl/timer0_waveform_control.sv
// Contract
// - Nonzero B mode hands pin to compare output
// - Non-PWM B modes: off, toggle, clear, set
// - Fast PWM B: clear/set on match, opposite TOP
// - Phase-correct B: direction decides clear or set
// - Match at TOP ignored, TOP action kept
// - Reserved control bits read back zero
// - Three-bit waveform mode picks sequence and TOP
// - Modes 0,1,2 TOP, update, overflow point
// - Modes 3,5,7 TOP, update, overflow point
// - Force strobes act only in non-PWM modes
// - Force strobe applies match using current mode
// - Force raises no flag, never clears counter
// - Force strobe bits always read zero
// - Clock select stop, undivided, prescaler taps
// - Select 6 falling, 7 rising external edges
// - External pin counts even when output
// - Counter readable and writable directly
// - Counter write blocks next tick's matches
// - Channel B compared with counter each count
// - B match sets flag; one clears it
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module timer0_waveform_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_pin,
  input wire logic vector_ack_b,
  output logic chan_a_wave_out,
  output logic chan_a_wave_out_en_n,
  output logic chan_b_wave_out,
  output logic chan_b_wave_out_en_n,
  output logic chan_b_match_flag
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    timer0_pkg::bus_e bus;      // APB phase
    logic [31:0] rdata;         // Read data register
    logic ready;                // Access acknowledge
    logic err;                  // Unmapped address answer
    logic [7:0] ctrlA;          // Output modes and low wave bits
    logic [7:0] ctrlB;          // High wave bit and clock select
    logic [7:0] count;          // Counter
    logic [7:0] matchA;         // Active compare A value
    logic [7:0] matchB;         // Active compare B value
    logic [7:0] bufA;           // Compare A buffer for PWM
    logic [7:0] bufB;           // Compare B buffer for PWM
    logic [2:0] flags;          // Match B, overflow, match A
    logic [1:0] pinDir;         // Pin direction bits
    logic countDown;            // Phase-correct direction
    logic blockMatch;           // Counter written, skip next tick
    logic [9:0] prescale;       // Free running prescaler
    logic [1:0] extSync;        // Two-stage pin synchroniser
    logic extLast;              // Previous synchronised level
    logic waveA;                // Channel A waveform
    logic waveB;                // Channel B waveform
    logic outA;                 // Pin value A
    logic outB;                 // Pin value B
    logic enA_n;                // Pin enable A, low drives
    logic enB_n;                // Pin enable B, low drives
  } state_s;

  state_s cur;
  state_s next_cur;

  // ------------------------------------------------------------
  // Combinational decode
  // ------------------------------------------------------------
  logic [2:0] waveMode;     // Combined waveform mode
  logic isFast;             // Fast PWM mode
  logic isPhase;            // Phase-correct mode
  logic isPwm;              // Either PWM mode
  logic [7:0] topVal;       // Current TOP
  logic tick;               // Selected timer clock tick
  logic setupOk;            // Bus request in setup
  logic wrStrobe;           // Write taken this edge
  logic [1:0] modeA;        // Channel A output mode
  logic [1:0] modeB;        // Channel B output mode

  always_comb begin
    waveMode = {cur.ctrlB[timer0_pkg::B_WAVE_HIGH_BIT],
                cur.ctrlA[timer0_pkg::A_WAVE_LOW_LSB +: 2]};
    isFast = (waveMode == timer0_pkg::WAVE_FAST_FF) || (waveMode == timer0_pkg::WAVE_FAST_A);
    isPhase = (waveMode == timer0_pkg::WAVE_PC_FF) || (waveMode == timer0_pkg::WAVE_PC_A);
    isPwm = isFast || isPhase;
    // TOP is the A compare value in modes 2, 5 and 7, else MAX
    if ((waveMode == timer0_pkg::WAVE_CLEAR_ON_MATCH) || (waveMode == timer0_pkg::WAVE_PC_A) ||
        (waveMode == timer0_pkg::WAVE_FAST_A)) begin
      topVal = cur.matchA;
    end else begin
      topVal = timer0_pkg::COUNT_MAX;
    end
    modeA = cur.ctrlA[timer0_pkg::A_OUT_MODE_A_LSB +: 2];
    modeB = cur.ctrlA[timer0_pkg::A_OUT_MODE_B_LSB +: 2];
    // Tick source; pin level seen only after the synchroniser
    case (cur.ctrlB[timer0_pkg::B_CLK_SEL_LSB +: 3])
      timer0_pkg::CLK_STOP: tick = 1'b0;
      timer0_pkg::CLK_DIV1: tick = 1'b1;
      timer0_pkg::CLK_DIV8: tick = (cur.prescale[2:0] == timer0_pkg::TAP_8[2:0]);
      timer0_pkg::CLK_DIV64: tick = (cur.prescale[5:0] == timer0_pkg::TAP_64[5:0]);
      timer0_pkg::CLK_DIV256: tick = (cur.prescale[7:0] == timer0_pkg::TAP_256[7:0]);
      timer0_pkg::CLK_DIV1024: tick = (cur.prescale == timer0_pkg::TAP_1024);
      // Pin direction is not consulted: driving it out still counts
      timer0_pkg::CLK_EXT_FALL: tick = cur.extLast && !cur.extSync[1];
      timer0_pkg::CLK_EXT_RISE: tick = !cur.extLast && cur.extSync[1];
      default: tick = 1'b0;
    endcase
    setupOk = psel && !penable;
    wrStrobe = (cur.bus == timer0_pkg::BUS_ACCESS) && psel && penable && pwrite;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic matchA;        // Compare A hit this tick
  logic matchB;        // Compare B hit this tick
  logic atTop;         // Counter at TOP on tick
  logic atBottom;      // Counter at BOTTOM on tick
  logic forceA;        // Force strobe A accepted
  logic forceB;        // Force strobe B accepted
  logic clearOnA;      // Mode 2 restart
  logic [7:0] wdata;   // Low byte of write data
  logic hitA;          // Waveform event A
  logic hitB;          // Waveform event B

  always_comb begin
    next_cur = cur;
    wdata = pwdata[7:0];
    next_cur.prescale = cur.prescale + 10'h001;
    next_cur.extSync = {cur.extSync[0], ext_count_pin};
    next_cur.extLast = cur.extSync[1];
    next_cur.ready = 1'b0;
    next_cur.err = 1'b0;

    // Compare on every count, unless a counter write just landed
    matchA = tick && !cur.blockMatch && (cur.count == cur.matchA);
    matchB = tick && !cur.blockMatch && (cur.count == cur.matchB);
    atTop = tick && (cur.count == topVal);
    atBottom = tick && (cur.count == timer0_pkg::COUNT_BOTTOM);
    clearOnA = matchA && (waveMode == timer0_pkg::WAVE_CLEAR_ON_MATCH);
    if (tick) begin
      next_cur.blockMatch = 1'b0;
    end

    // Counter sequence per waveform mode
    if (tick) begin
      if (isPhase) begin
        if (!cur.countDown && cur.count == topVal) begin
          next_cur.countDown = 1'b1;
          next_cur.count = cur.count - 8'h01;
        end else if (cur.countDown && cur.count == timer0_pkg::COUNT_BOTTOM) begin
          next_cur.countDown = 1'b0;
          next_cur.count = cur.count + 8'h01;
        end else begin
          next_cur.count = cur.countDown ? cur.count - 8'h01 : cur.count + 8'h01;
        end
      end else if (clearOnA || (isFast && atTop)) begin
        next_cur.count = timer0_pkg::COUNT_BOTTOM;
        next_cur.countDown = 1'b0;
      end else begin
        next_cur.count = cur.count + 8'h01;
        next_cur.countDown = 1'b0;
      end
    end

    // Buffered compare values load at TOP in PWM modes
    if (!isPwm) begin
      next_cur.matchA = cur.bufA;
      next_cur.matchB = cur.bufB;
    end else if (atTop) begin
      next_cur.matchA = cur.bufA;
      next_cur.matchB = cur.bufB;
    end

    // Force strobes only in non-PWM modes, never touch flags or counter
    forceA = wrStrobe && (paddr == timer0_pkg::ADDR_CTRL_B) && wdata[timer0_pkg::B_FORCE_A_BIT] && !isPwm;
    forceB = wrStrobe && (paddr == timer0_pkg::ADDR_CTRL_B) && wdata[timer0_pkg::B_FORCE_B_BIT] && !isPwm;

    // Waveform logic; in PWM modes a match at TOP with upper mode bit is ignored
    hitA = matchA && !(isPwm && cur.matchA == topVal && modeA[1]);
    hitB = matchB && !(isPwm && cur.matchB == topVal && modeB[1]);
    if (!isPwm) begin
      if (hitB || forceB) begin
        case (modeB)
          timer0_pkg::OUT_TOGGLE: next_cur.waveB = !cur.waveB;
          timer0_pkg::OUT_CLEAR: next_cur.waveB = 1'b0;
          timer0_pkg::OUT_SET: next_cur.waveB = 1'b1;
          default: next_cur.waveB = cur.waveB;
        endcase
      end
      if (hitA || forceA) begin
        case (modeA)
          timer0_pkg::OUT_TOGGLE: next_cur.waveA = !cur.waveA;
          timer0_pkg::OUT_CLEAR: next_cur.waveA = 1'b0;
          timer0_pkg::OUT_SET: next_cur.waveA = 1'b1;
          default: next_cur.waveA = cur.waveA;
        endcase
      end
    end else if (isFast) begin
      // Mode 01 reserved for B; for A it toggles only with TOP from A
      if (modeB[1] && atTop) begin
        next_cur.waveB = !modeB[0];
      end else if (modeB[1] && hitB) begin
        next_cur.waveB = modeB[0];
      end
      if (modeA[1] && atTop) begin
        next_cur.waveA = !modeA[0];
      end else if (modeA[1] && hitA) begin
        next_cur.waveA = modeA[0];
      end else if (modeA == timer0_pkg::OUT_TOGGLE && waveMode[2] && hitA) begin
        next_cur.waveA = !cur.waveA;
      end
    end else begin
      // Phase correct: up-count match uses mode bit 0, down inverts it
      if (modeB[1] && hitB) begin
        next_cur.waveB = cur.countDown ? !modeB[0] : modeB[0];
      end else if (modeB[1] && atTop && cur.matchB == topVal) begin
        next_cur.waveB = modeB[0];
      end
      if (modeA[1] && hitA) begin
        next_cur.waveA = cur.countDown ? !modeA[0] : modeA[0];
      end else if (modeA[1] && atTop && cur.matchA == topVal) begin
        next_cur.waveA = modeA[0];
      end else if (modeA == timer0_pkg::OUT_TOGGLE && waveMode[2] && hitA) begin
        next_cur.waveA = !cur.waveA;
      end
    end

    // Pin takeover; enable only with direction bit set
    next_cur.outA = (modeA != timer0_pkg::OUT_OFF) ? next_cur.waveA : 1'b0;
    next_cur.outB = (modeB != timer0_pkg::OUT_OFF) ? next_cur.waveB : 1'b0;
    next_cur.enA_n = !((modeA != timer0_pkg::OUT_OFF) && cur.pinDir[timer0_pkg::DIR_A_BIT]);
    next_cur.enB_n = !((modeB != timer0_pkg::OUT_OFF) && cur.pinDir[timer0_pkg::DIR_B_BIT]);

    // Flag set wins over a same-cycle clear
    if (vector_ack_b) begin
      next_cur.flags[timer0_pkg::FLAG_MATCH_B_BIT] = 1'b0;
    end
    if (wrStrobe && paddr == timer0_pkg::ADDR_FLAGS) begin
      next_cur.flags = cur.flags & ~wdata[2:0];
    end
    if (wrStrobe && paddr == timer0_pkg::ADDR_FLAGS && vector_ack_b) begin
      next_cur.flags[timer0_pkg::FLAG_MATCH_B_BIT] = 1'b0;
    end
    if (matchB) begin
      next_cur.flags[timer0_pkg::FLAG_MATCH_B_BIT] = 1'b1;
    end
    if (matchA) begin
      next_cur.flags[timer0_pkg::FLAG_MATCH_A_BIT] = 1'b1;
    end
    if ((isPhase && atBottom) || (waveMode == timer0_pkg::WAVE_FAST_A && atTop) ||
        (!isPhase && waveMode != timer0_pkg::WAVE_FAST_A && tick &&
         cur.count == timer0_pkg::COUNT_MAX)) begin
      next_cur.flags[timer0_pkg::FLAG_OVERFLOW_BIT] = 1'b1;
    end

    // APB slave: one wait-free access phase
    case (cur.bus)
      timer0_pkg::BUS_IDLE: begin
        if (setupOk) begin
          next_cur.bus = timer0_pkg::BUS_ACCESS;
          next_cur.ready = 1'b1;
          next_cur.err = !(paddr inside {timer0_pkg::ADDR_CTRL_A, timer0_pkg::ADDR_CTRL_B,
                           timer0_pkg::ADDR_COUNT, timer0_pkg::ADDR_MATCH_A, timer0_pkg::ADDR_MATCH_B,
                           timer0_pkg::ADDR_FLAGS, timer0_pkg::ADDR_PIN_DIR});
          case (paddr)
            timer0_pkg::ADDR_CTRL_A: next_cur.rdata = {24'h0, cur.ctrlA & timer0_pkg::CTRL_A_MASK};
            timer0_pkg::ADDR_CTRL_B: next_cur.rdata = {24'h0, cur.ctrlB & timer0_pkg::CTRL_B_MASK};
            timer0_pkg::ADDR_COUNT: next_cur.rdata = {24'h0, cur.count};
            timer0_pkg::ADDR_MATCH_A: next_cur.rdata = {24'h0, cur.bufA};
            timer0_pkg::ADDR_MATCH_B: next_cur.rdata = {24'h0, cur.bufB};
            timer0_pkg::ADDR_FLAGS: next_cur.rdata = {29'h0, cur.flags};
            timer0_pkg::ADDR_PIN_DIR: next_cur.rdata = {30'h0, cur.pinDir};
            default: next_cur.rdata = 32'h0;
          endcase
        end
      end
      timer0_pkg::BUS_ACCESS: begin
        next_cur.bus = timer0_pkg::BUS_IDLE;
        if (wrStrobe) begin
          case (paddr)
            timer0_pkg::ADDR_CTRL_A: next_cur.ctrlA = wdata & timer0_pkg::CTRL_A_MASK;
            timer0_pkg::ADDR_CTRL_B: next_cur.ctrlB = wdata & timer0_pkg::CTRL_B_MASK;
            timer0_pkg::ADDR_COUNT: begin
              next_cur.count = wdata;
              next_cur.blockMatch = 1'b1;
            end
            timer0_pkg::ADDR_MATCH_A: next_cur.bufA = wdata;
            timer0_pkg::ADDR_MATCH_B: next_cur.bufB = wdata;
            timer0_pkg::ADDR_PIN_DIR: next_cur.pinDir = wdata[1:0];
            default: next_cur.pinDir = cur.pinDir;
          endcase
        end
      end
      default: next_cur.bus = timer0_pkg::BUS_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Register the whole state
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
      cur.enA_n <= 1'b1;
      cur.enB_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;
  assign chan_a_wave_out = cur.outA;
  assign chan_a_wave_out_en_n = cur.enA_n;
  assign chan_b_wave_out = cur.outB;
  assign chan_b_wave_out_en_n = cur.enB_n;
  assign chan_b_match_flag = cur.flags[timer0_pkg::FLAG_MATCH_B_BIT];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  pin_release_a: assert property (@(posedge clk) disable iff (reset)
    (modeB == timer0_pkg::OUT_OFF) |=> chan_b_wave_out_en_n) else $error("pin driven while disconnected");
  toggle_b_a: assert property (@(posedge clk) disable iff (reset)
    (!isPwm && matchB && modeB == timer0_pkg::OUT_TOGGLE) |=> (cur.waveB != $past(cur.waveB)))
    else $error("toggle missed");
  fast_top_a: assert property (@(posedge clk) disable iff (reset)
    (isFast && atTop && modeB == timer0_pkg::OUT_CLEAR) |=> cur.waveB) else $error("fast TOP set missed");
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    (cur.ctrlA[3:2] == 2'h0) && (cur.ctrlB[5:4] == 2'h0)) else $error("reserved bit set");
  force_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (forceB && !matchB && !vector_ack_b) |=> ($stable(cur.flags[2]))) else $error("force raised flag");
  force_zero_a: assert property (@(posedge clk) disable iff (reset)
    cur.ctrlB[7:6] == 2'h0) else $error("force bit stored");
  block_match_a: assert property (@(posedge clk) disable iff (reset)
    (cur.blockMatch && tick) |-> !matchB && !matchA) else $error("match after count write");
  flag_set_a: assert property (@(posedge clk) disable iff (reset)
    matchB |=> chan_b_match_flag) else $error("match flag not set");
  stop_hold_a: assert property (@(posedge clk) disable iff (reset)
    (cur.ctrlB[2:0] == timer0_pkg::CLK_STOP && !wrStrobe) |=> $stable(cur.count)) else $error("stopped counter moved");

endmodule

`default_nettype wire

// >>> rtl/timer0_pkg.sv
package timer0_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;  // timer_waveform_control_a
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;  // timer_waveform_control_b
  localparam logic [7:0] ADDR_COUNT = 8'h08;  // timer_count_value
  localparam logic [7:0] ADDR_MATCH_A = 8'h0c;  // chan_a_match_value
  localparam logic [7:0] ADDR_MATCH_B = 8'h10;  // chan_b_match_value
  localparam logic [7:0] ADDR_FLAGS = 8'h14;  // Status flags, write one to clear
  localparam logic [7:0] ADDR_PIN_DIR = 8'h18;  // Pin direction bits

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int A_OUT_MODE_A_LSB = 6;
  localparam int A_OUT_MODE_B_LSB = 4;
  localparam int A_WAVE_LOW_LSB = 0;
  localparam int B_FORCE_A_BIT = 7;
  localparam int B_FORCE_B_BIT = 6;
  localparam int B_WAVE_HIGH_BIT = 3;
  localparam int B_CLK_SEL_LSB = 0;
  localparam int FLAG_MATCH_B_BIT = 2;
  localparam int FLAG_OVERFLOW_BIT = 1;
  localparam int FLAG_MATCH_A_BIT = 0;
  localparam int DIR_A_BIT = 0;
  localparam int DIR_B_BIT = 1;

  // Readable masks: reserved bits read as zero
  localparam logic [7:0] CTRL_A_MASK = 8'hf3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0f;
  localparam logic [7:0] FLAGS_MASK = 8'h07;
  localparam logic [7:0] DIR_MASK = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ------------------------------------------------------------
  // Counter limits and prescaler taps
  // ------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [9:0] TAP_8 = 10'h007;
  localparam logic [9:0] TAP_64 = 10'h03f;
  localparam logic [9:0] TAP_256 = 10'h0ff;
  localparam logic [9:0] TAP_1024 = 10'h3ff;

  // Output mode encodings
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

  // Clock select encodings
  localparam logic [2:0] CLK_STOP = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_DIV1024 = 3'h5;
  localparam logic [2:0] CLK_EXT_FALL = 3'h6;
  localparam logic [2:0] CLK_EXT_RISE = 3'h7;

  // Waveform modes
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_PC_FF = 3'h1;
  localparam logic [2:0] WAVE_CLEAR_ON_MATCH = 3'h2;
  localparam logic [2:0] WAVE_FAST_FF = 3'h3;
  localparam logic [2:0] WAVE_PC_A = 3'h5;
  localparam logic [2:0] WAVE_FAST_A = 3'h7;

  // APB access phase, Gray coded along idle -> access
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACCESS = 1'b1
  } bus_e;

endpackage

// >>> bench/timer0_waveform_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module timer0_waveform_control_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic extPin = 1'b0; // Idle low before any external-clock test
  logic vectorAck = 1'b0;
  logic waveA, waveAEnN, waveB, waveBEnN, matchFlag;
  int errorCnt = 0;
  int comparisons = 0;
  int cycles = 0; // Hang guard, the whole run needs about 32k cycles
  int hi;
  logic [31:0] rd; // Last read data
  logic err; // Last slave error
  // Register table rows: address, write byte, read-back byte, error
  logic [7:0] ra[5] = '{timer0_pkg::ADDR_CTRL_A, timer0_pkg::ADDR_CTRL_B, timer0_pkg::ADDR_COUNT,
                        timer0_pkg::ADDR_MATCH_B, 8'h1c};
  logic [7:0] rw[5] = '{8'hff, 8'hf0, 8'h5a, 8'h80, 8'h12};
  logic [7:0] re[5] = '{8'hf3, 8'h00, 8'h5a, 8'h80, 8'h00};
  logic rb[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  int dv[6] = '{0, 1, 8, 64, 256, 1024}; // Divisor per clock select
  // Waveform rows: control A, compare value, window, expected high cycles
  // Last row is clear-on-match with TOP from compare A, toggling B
  logic [7:0] pa[5] = '{8'h23, 8'h33, 8'h21, 8'h23, 8'h12};
  logic [7:0] pv[5] = '{8'h40, 8'h40, 8'h40, 8'hff, 8'h40};
  int pw[5] = '{256, 256, 510, 256, 256};
  int ph[5] = '{64, 192, 128, 256, 128};

  always #20 clk = ~clk;

  timer0_waveform_control timer0_waveform_control_inst (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_count_pin(extPin), .vector_ack_b(vectorAck),
    .chan_a_wave_out(waveA), .chan_a_wave_out_en_n(waveAEnN), .chan_b_wave_out(waveB),
    .chan_b_wave_out_en_n(waveBEnN), .chan_b_match_flag(matchFlag));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task results;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Exact compare, four-state safe
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compare with tolerance; prescaler phase and pipeline make counts fuzzy
  task near(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol);
    comparisons++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk({31'h0, pready}, 32'h1);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(a, 1'b0, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  // Let registered outputs land before they are looked at
  task settle;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, cycles, 0);
      results();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({29'h0, waveAEnN, waveBEnN, matchFlag}, 32'h6);
    rdchk(timer0_pkg::ADDR_CTRL_A, 8'h00);
    rdchk(timer0_pkg::ADDR_CTRL_B, 8'h00);
    rdchk(timer0_pkg::ADDR_FLAGS, 8'h00);
    $display("Test reset done");
    // Table rows, counter stopped throughout
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], rw[i]);
      rdchk(ra[i], re[i]);
      chk({31'h0, err}, {31'h0, rb[i]});
    end
    $display("Test register table done");
    // Force strobes in normal mode, both channels toggling then set then clear
    wr(timer0_pkg::ADDR_PIN_DIR, 8'h03);
    wr(timer0_pkg::ADDR_CTRL_A, 8'h50);
    settle();
    chk({30'h0, waveAEnN, waveBEnN}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(timer0_pkg::ADDR_CTRL_A, 8'hf0);
      if (k == 3) wr(timer0_pkg::ADDR_CTRL_A, 8'ha0);
      wr(timer0_pkg::ADDR_CTRL_B, 8'hc0);
      settle();
      chk({30'h0, waveA, waveB}, (k == 1 || k == 3) ? 32'h0 : 32'h3);
    end
    chk({31'h0, matchFlag}, 32'h0);
    rdchk(timer0_pkg::ADDR_COUNT, 8'h5a);
    wr(timer0_pkg::ADDR_CTRL_A, 8'hf3);
    wr(timer0_pkg::ADDR_CTRL_B, 8'hc0);
    settle();
    chk({30'h0, waveA, waveB}, 32'h0);
    wr(timer0_pkg::ADDR_PIN_DIR, 8'h00);
    settle();
    chk({30'h0, waveAEnN, waveBEnN}, 32'h3);
    $display("Test force strobes done");
    // Every internal clock select, normal mode
    wr(timer0_pkg::ADDR_CTRL_A, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(timer0_pkg::ADDR_COUNT, 8'h00);
      wr(timer0_pkg::ADDR_CTRL_B, i[7:0]);
      repeat ((dv[i] != 0) ? dv[i] * 20 - 2 : 98) @(posedge clk);
      wr(timer0_pkg::ADDR_CTRL_B, 8'h00);
      apb(timer0_pkg::ADDR_COUNT, 1'b0, 8'h00);
      near(rd, (dv[i] != 0) ? 32'd20 : 32'd0, (dv[i] != 0) ? 32'd2 : 32'd0);
    end
    // External pin, falling then rising edges, five pulses each
    for (int s = 6; s < 8; s++) begin
      extPin <= (s == 6);
      wr(timer0_pkg::ADDR_COUNT, 8'h00);
      wr(timer0_pkg::ADDR_CTRL_B, s[7:0]);
      repeat (10) begin
        repeat (4) @(posedge clk);
        extPin <= ~extPin;
      end
      repeat (6) @(posedge clk);
      wr(timer0_pkg::ADDR_CTRL_B, 8'h00);
      rdchk(timer0_pkg::ADDR_COUNT, 8'h05);
    end
    $display("Test clock select done");
    // Compare match flag, vector clear, write-one clear, blocked match
    wr(timer0_pkg::ADDR_MATCH_B, 8'h05);
    for (int k = 0; k < 3; k++) begin
      wr(timer0_pkg::ADDR_FLAGS, 8'h07);
      wr(timer0_pkg::ADDR_COUNT, (k == 2) ? 8'h05 : 8'h00);
      wr(timer0_pkg::ADDR_CTRL_B, 8'h01);
      repeat ((k == 2) ? 1 : 20) @(posedge clk);
      wr(timer0_pkg::ADDR_CTRL_B, 8'h00);
      settle();
      chk({31'h0, matchFlag}, (k == 2) ? 32'h0 : 32'h1);
      if (k == 0) begin
        vectorAck <= 1'b1;
        @(posedge clk);
        vectorAck <= 1'b0;
      end else begin
        wr(timer0_pkg::ADDR_FLAGS, 8'h04);
      end
      settle();
      chk({31'h0, matchFlag}, 32'h0);
    end
    $display("Test match flag done");
    // PWM duty over a whole period, compare value settled at TOP first
    wr(timer0_pkg::ADDR_PIN_DIR, 8'h02);
    wr(timer0_pkg::ADDR_MATCH_A, 8'h7f); // TOP for the clear-on-match row
    for (int i = 0; i < 5; i++) begin
      wr(timer0_pkg::ADDR_CTRL_B, 8'h00);
      wr(timer0_pkg::ADDR_CTRL_A, pa[i]);
      wr(timer0_pkg::ADDR_MATCH_B, pv[i]);
      wr(timer0_pkg::ADDR_CTRL_B, 8'h01);
      repeat (600) @(posedge clk);
      hi = 0;
      repeat (pw[i]) begin
        @(posedge clk);
        hi += (waveB === 1'b1);
      end
      near(hi, ph[i], 32'd4);
    end
    chk({31'h0, waveBEnN}, 32'h0);
    $display("Test pwm done");
    // Reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk({30'h0, waveBEnN, waveB}, 32'h2);
    rdchk(timer0_pkg::ADDR_CTRL_A, 8'h00);
    $display("Test second reset done");
    results();
  end
endmodule

`default_nettype wire
